// ---- src/cal_sequencer.sv ----
// Core reference clock PLL calibration sequencer: band then amplitude search
`timescale 1ns/10ps
module cal_sequencer #(
  parameter logic [15:0] SETTLE_CYCLES = 16'(opctl_pkg::CAL_SETTLE_CYCLES)
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       start,
  input  wire logic       tune_in_range,
  input  wire logic       amp_in_range,
  output logic            busy,
  output logic [3:0]      vco_band,
  output logic [2:0]      vco_amp,
  output logic            done
);

  opctl_pkg::seq_state_t s_q;
  opctl_pkg::seq_state_t s_d;

  // ==========================================================================
  // Search: each trial settles, then the range flag decides
  always_comb
  begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      opctl_pkg::CAL_IDLE:
      begin
        if (start)
        begin
          s_d.st   = opctl_pkg::CAL_BAND;
          s_d.band = '0;
          s_d.amp  = '0;
          s_d.cnt  = SETTLE_CYCLES;
          s_d.busy = 1'b1;
        end
      end
      opctl_pkg::CAL_BAND:
      begin
        if (s_q.cnt != '0)
          s_d.cnt = s_q.cnt - 16'h0001;
        else if (tune_in_range || s_q.band == opctl_pkg::BAND_LAST)
        begin
          s_d.st  = opctl_pkg::CAL_AMP;
          s_d.cnt = SETTLE_CYCLES;
        end
        else
        begin
          s_d.band = s_q.band + 4'h1;
          s_d.cnt  = SETTLE_CYCLES;
        end
      end
      opctl_pkg::CAL_AMP:
      begin
        if (s_q.cnt != '0)
          s_d.cnt = s_q.cnt - 16'h0001;
        else if (amp_in_range || s_q.amp == opctl_pkg::AMP_LAST)
        begin
          s_d.st   = opctl_pkg::CAL_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
        else
        begin
          s_d.amp = s_q.amp + 3'h1;
          s_d.cnt = SETTLE_CYCLES;
        end
      end
      default:
      begin
        s_d.st   = opctl_pkg::CAL_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.st   <= opctl_pkg::CAL_IDLE;
      s_q.cnt  <= '0;
      s_q.band <= '0;
      s_q.amp  <= '0;
      s_q.busy <= 1'b0;
      s_q.done <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  assign busy     = s_q.busy;
  assign vco_band = s_q.band;
  assign vco_amp  = s_q.amp;
  assign done     = s_q.done;

  // ==========================================================================
  // Checks
  band_settle_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == opctl_pkg::CAL_BAND && s_q.cnt != '0) |=> (s_q.st == opctl_pkg::CAL_BAND && s_q.band == $past(s_q.band)))
    else $error("band changed before settling ended");
  band_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.st == opctl_pkg::CAL_BAND && s_q.cnt == '0 && !tune_in_range && s_q.band != opctl_pkg::BAND_LAST)
      |=> (s_q.band == $past(s_q.band) + 4'h1 && s_q.cnt == SETTLE_CYCLES))
    else $error("band search did not advance");
  start_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    (start && s_q.st == opctl_pkg::CAL_IDLE) |=> busy [*2])
    else $error("calibration start did not stall the core clock");
  done_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(busy) |-> (done && s_q.st == opctl_pkg::CAL_IDLE))
    else $error("busy dropped without completion");

endmodule

// ---- src/opctl_pkg.sv ----
// Constants, field layouts and carrier types for the operational control strobe bank
package opctl_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_NS     = 10;
  localparam int unsigned CAL_SETTLE_NS     = 100000;
  localparam int unsigned CAL_SETTLE_CYCLES = (CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W          = 16;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [11:0] CALSYNC_IDX    = 12'hA02;
  localparam logic [11:0] FUNC_IDX       = 12'hA03;
  localparam logic [11:0] CORE_REFERENCE_CLOCK_CLR_IDX = 12'hA04;
  localparam logic [11:0] MISC_CLR_IDX   = 12'hA05;
  localparam logic [11:0] PLL_CLR_IDX    = 12'hA06;
  localparam logic [11:0] LIMIT_CLR_IDX  = 12'hA07;
  localparam logic [11:0] STATUS_IDX     = 12'hA1E;
  localparam logic [11:0] UPDATE_IDX     = 12'hA1F;

  // ==========================================================================
  // Field positions, masks and reset values
  localparam int unsigned CS_CAL_BIT     = 0;
  localparam int unsigned CS_SYNC_BIT    = 1;
  localparam int unsigned FUNC_CLR_ALL   = 1;
  localparam int unsigned UPD_BIT        = 0;
  localparam logic [7:0]  CALSYNC_MASK   = 8'h03;
  localparam logic [7:0]  FUNC_MASK      = 8'h7F;
  localparam logic [7:0]  CORE_REFERENCE_CLOCK_MASK    = 8'h33;
  localparam logic [7:0]  MISC_MASK      = 8'h0F;
  localparam logic [7:0]  PLL_MASK       = 8'hFF;
  localparam logic [7:0]  LIMIT_MASK     = 8'h1F;
  localparam logic [7:0]  CALSYNC_RST    = 8'h00;
  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_STALL_BIT   = 1;
  localparam int unsigned ST_COMMIT_BIT  = 2;
  localparam int unsigned ST_BAND_LSB    = 4;
  localparam int unsigned ST_AMP_LSB     = 8;

  // ==========================================================================
  // Calibration search space
  localparam int unsigned BAND_W    = 4;
  localparam int unsigned AMP_W     = 3;
  localparam logic [3:0]  BAND_LAST = 4'hF;
  localparam logic [2:0]  AMP_LAST  = 3'h7;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {CAL_IDLE, CAL_BAND, CAL_AMP} cal_state_t;

  typedef struct packed {
    logic wipe_loop_filter;
    logic comb_integrator_clear;
    logic numeric_synthesizer_acc_clear;
    logic auto_sync_reset;
    logic tuning_word_history_reset;
    logic clear_every_interrupt;
    logic watchdog_restart;
  } func_strobe_t;

  typedef struct packed {
    logic [7:0] limit;
    logic [7:0] pll;
    logic [7:0] misc;
    logic [7:0] core_reference_clock;
  } irq_clear_t;

  typedef struct packed {
    cal_state_t           st;
    logic [SETTLE_W-1:0]  cnt;
    logic [BAND_W-1:0]    band;
    logic [AMP_W-1:0]     amp;
    logic                 busy;
    logic                 done;
  } seq_state_t;

  typedef struct packed {
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic [7:0]   calsync;
    logic         cal_commit;
    logic         cal_start;
    logic         dist_sync;
    func_strobe_t func;
    irq_clear_t   irq;
  } ctl_state_t;

  // Word decode of a byte address against a register index
  function automatic logic reg_hit(input logic [15:0] addr, input logic [11:0] idx);
    return addr[15:2] == {2'b00, idx};
  endfunction

endpackage

// ---- src/operational_control_strobes.sv ----
// Operational control strobe bank: calibration, distribution sync, function resets, interrupt clears
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
module operational_control_strobes #(
  parameter logic [15:0] SETTLE_CYCLES = 16'(opctl_pkg::CAL_SETTLE_CYCLES)
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic [15:0]       paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              syspll_enable,
  input  wire logic              tune_in_range,
  input  wire logic              amp_in_range,
  output logic                   dist_stall,
  output logic                   dist_sync,
  output logic                   core_clock_stall,
  output logic [3:0]             vco_band,
  output logic [2:0]             vco_amp,
  output logic                   cal_done,
  output opctl_pkg::func_strobe_t func_strobe,
  output opctl_pkg::irq_clear_t   irq_clear
);

  opctl_pkg::ctl_state_t s_q;
  opctl_pkg::ctl_state_t s_d;
  logic                  cal_busy;
  logic                  access;
  logic                  wr_en;
  logic                  mapped;
  logic                  strobe_reg;
  logic [31:0]           rd_val;
  logic [7:0]            wbyte;

  assign access = psel && penable;
  assign wr_en  = access && s_q.pready && pwrite && !s_q.pslverr;
  assign wbyte  = pwdata[7:0];

  // ==========================================================================
  // Address decode and read data
  always_comb
  begin
    mapped     = 1'b1;
    strobe_reg = 1'b0;
    rd_val     = 32'h0000_0000;
    if (opctl_pkg::reg_hit(paddr, opctl_pkg::CALSYNC_IDX))
      rd_val[7:0] = s_q.calsync & opctl_pkg::CALSYNC_MASK;
    else if (opctl_pkg::reg_hit(paddr, opctl_pkg::FUNC_IDX))
      strobe_reg = 1'b1;
    else if (opctl_pkg::reg_hit(paddr, opctl_pkg::CORE_REFERENCE_CLOCK_CLR_IDX))
      strobe_reg = 1'b1;
    else if (opctl_pkg::reg_hit(paddr, opctl_pkg::MISC_CLR_IDX))
      strobe_reg = 1'b1;
    else if (opctl_pkg::reg_hit(paddr, opctl_pkg::PLL_CLR_IDX))
      strobe_reg = 1'b1;
    else if (opctl_pkg::reg_hit(paddr, opctl_pkg::LIMIT_CLR_IDX))
      strobe_reg = 1'b1;
    else if (opctl_pkg::reg_hit(paddr, opctl_pkg::STATUS_IDX))
    begin
      rd_val[opctl_pkg::ST_BUSY_BIT]   = cal_busy;
      rd_val[opctl_pkg::ST_STALL_BIT]  = s_q.calsync[opctl_pkg::CS_SYNC_BIT];
      rd_val[opctl_pkg::ST_COMMIT_BIT] = s_q.cal_commit;
      rd_val[opctl_pkg::ST_BAND_LSB +: opctl_pkg::BAND_W] = vco_band;
      rd_val[opctl_pkg::ST_AMP_LSB +: opctl_pkg::AMP_W]   = vco_amp;
    end
    else if (opctl_pkg::reg_hit(paddr, opctl_pkg::UPDATE_IDX))
      mapped = 1'b1;
    else
      mapped = 1'b0;
  end

  // ==========================================================================
  // Bus handshake, register writes and strobes
  always_comb
  begin
    s_d           = s_q;
    s_d.cal_start = 1'b0;
    s_d.dist_sync = 1'b0;
    s_d.func      = '0;
    s_d.irq       = '0;
    if (access && !s_q.pready)
    begin
      s_d.pready  = 1'b1;
      s_d.prdata  = pwrite ? 32'h0000_0000 : rd_val;
      // Function and interrupt-clear strobe writes are refused while the core clock is stalled
      s_d.pslverr = !mapped || (pwrite && strobe_reg && cal_busy);
    end
    else if (access && s_q.pready)
    begin
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
    end
    if (wr_en)
    begin
      if (opctl_pkg::reg_hit(paddr, opctl_pkg::CALSYNC_IDX))
      begin
        s_d.calsync = wbyte & opctl_pkg::CALSYNC_MASK;
        if (s_q.calsync[opctl_pkg::CS_SYNC_BIT] && !wbyte[opctl_pkg::CS_SYNC_BIT])
          s_d.dist_sync = 1'b1;
      end
      else if (opctl_pkg::reg_hit(paddr, opctl_pkg::FUNC_IDX))
      begin
        s_d.func = opctl_pkg::func_strobe_t'(wbyte[6:0] & opctl_pkg::FUNC_MASK[6:0]);
        if (wbyte[opctl_pkg::FUNC_CLR_ALL])
        begin
          s_d.irq.core_reference_clock = opctl_pkg::CORE_REFERENCE_CLOCK_MASK;
          s_d.irq.misc   = opctl_pkg::MISC_MASK;
          s_d.irq.pll    = opctl_pkg::PLL_MASK;
          s_d.irq.limit  = opctl_pkg::LIMIT_MASK;
        end
      end
      else if (opctl_pkg::reg_hit(paddr, opctl_pkg::CORE_REFERENCE_CLOCK_CLR_IDX))
        s_d.irq.core_reference_clock = wbyte & opctl_pkg::CORE_REFERENCE_CLOCK_MASK;
      else if (opctl_pkg::reg_hit(paddr, opctl_pkg::MISC_CLR_IDX))
        s_d.irq.misc = wbyte & opctl_pkg::MISC_MASK;
      else if (opctl_pkg::reg_hit(paddr, opctl_pkg::PLL_CLR_IDX))
        s_d.irq.pll = wbyte & opctl_pkg::PLL_MASK;
      else if (opctl_pkg::reg_hit(paddr, opctl_pkg::LIMIT_CLR_IDX))
        s_d.irq.limit = wbyte & opctl_pkg::LIMIT_MASK;
      else if (opctl_pkg::reg_hit(paddr, opctl_pkg::UPDATE_IDX) && wbyte[opctl_pkg::UPD_BIT])
      begin
        // Commit staged calibration bit; only a committed rise starts a run
        s_d.cal_commit = s_q.calsync[opctl_pkg::CS_CAL_BIT];
        if (s_q.calsync[opctl_pkg::CS_CAL_BIT] && !s_q.cal_commit && syspll_enable && !cal_busy)
          s_d.cal_start = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q.pready     <= 1'b0;
      s_q.pslverr    <= 1'b0;
      s_q.prdata     <= 32'h0000_0000;
      s_q.calsync    <= opctl_pkg::CALSYNC_RST;
      s_q.cal_commit <= 1'b0;
      s_q.cal_start  <= 1'b0;
      s_q.dist_sync  <= 1'b0;
      s_q.func       <= '0;
      s_q.irq        <= '0;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================================
  // Calibration engine
  cal_sequencer #(
    .SETTLE_CYCLES (SETTLE_CYCLES)
  ) u_cal (
    .pclk          (pclk),
    .presetn       (presetn),
    .start         (s_q.cal_start),
    .tune_in_range (tune_in_range),
    .amp_in_range  (amp_in_range),
    .busy          (cal_busy),
    .vco_band      (vco_band),
    .vco_amp       (vco_amp),
    .done          (cal_done)
  );

  // ==========================================================================
  // Outputs
  assign prdata           = s_q.prdata;
  assign pready           = s_q.pready;
  assign pslverr          = s_q.pslverr;
  assign dist_stall       = s_q.calsync[opctl_pkg::CS_SYNC_BIT];
  assign dist_sync        = s_q.dist_sync;
  assign core_clock_stall = cal_busy;
  assign func_strobe      = s_q.func;
  assign irq_clear        = s_q.irq;

  // ==========================================================================
  // Checks
  stall_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && opctl_pkg::reg_hit(paddr, opctl_pkg::CALSYNC_IDX)) |=> (dist_stall == $past(pwdata[1])))
    else $error("distribution stall does not follow sync bit");
  sync_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
    dist_sync |-> ($past(dist_stall) && !dist_stall))
    else $error("sync pulse without a falling request");
  sync_no_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(dist_stall) |-> !dist_sync)
    else $error("sync fired on setting the request");
  cal_launch_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && opctl_pkg::reg_hit(paddr, opctl_pkg::UPDATE_IDX) && pwdata[0] && s_q.calsync[0] && !s_q.cal_commit
      && syspll_enable && !cal_busy) |=> ##1 core_clock_stall)
    else $error("committed calibration rise did not start calibration");
  cal_disabled_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.cal_start |-> $past(syspll_enable))
    else $error("calibration started with the PLL disabled");
  func_selfclear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (func_strobe != '0) |=> (func_strobe == '0))
    else $error("function strobe held longer than one cycle");
  irq_all_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && opctl_pkg::reg_hit(paddr, opctl_pkg::FUNC_IDX) && pwdata[1])
      |=> (irq_clear == {opctl_pkg::LIMIT_MASK, opctl_pkg::PLL_MASK, opctl_pkg::MISC_MASK, opctl_pkg::CORE_REFERENCE_CLOCK_MASK}))
    else $error("global clear missed some interrupt bits");
  irq_selfclear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_clear != '0) |=> (irq_clear == '0))
    else $error("interrupt clear held longer than one cycle");
  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((irq_clear.core_reference_clock & ~opctl_pkg::CORE_REFERENCE_CLOCK_MASK) == 8'h00) && ((irq_clear.misc & ~opctl_pkg::MISC_MASK) == 8'h00)
      && ((irq_clear.limit & ~opctl_pkg::LIMIT_MASK) == 8'h00) && ((s_q.calsync & ~opctl_pkg::CALSYNC_MASK) == 8'h00))
    else $error("unused bit set");
  core_reference_clock_map_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && opctl_pkg::reg_hit(paddr, opctl_pkg::CORE_REFERENCE_CLOCK_CLR_IDX))
      |=> (irq_clear.core_reference_clock == ($past(pwdata[7:0]) & opctl_pkg::CORE_REFERENCE_CLOCK_MASK)))
    else $error("core clock clear bits mismapped");

endmodule

// ---- verification/tb_operational_control_strobes.sv ----
// Self-checking testbench for the operational control strobe bank
`timescale 1ns/10ps
`define CHK(got, exp, msg) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("wrong value at %0t ns: %s", $time, msg); \
    end \
  end

module tb_operational_control_strobes;
  localparam logic [15:0] SETTLE         = 16'h0004;
  localparam int unsigned TIMEOUT_CYCLES = 20000;

  logic                    pclk;
  logic                    presetn;
  logic [15:0]             paddr;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic                    syspll_enable;
  logic                    tune_in_range;
  logic                    amp_in_range;
  logic                    dist_stall;
  logic                    dist_sync;
  logic                    core_clock_stall;
  logic [3:0]              vco_band;
  logic [2:0]              vco_amp;
  logic                    cal_done;
  opctl_pkg::func_strobe_t func_strobe;
  opctl_pkg::irq_clear_t   irq_clear;
  int                      num_errors = 0;
  int                      samples_checked = 0;
  int                      cycles = 0;
  int                      done_cnt = 0;
  logic [31:0]             rd;
  logic                    err;
  logic                    hit;
  logic [7:0]              irq_masks [4] = '{8'h33, 8'h0F, 8'hFF, 8'h1F};

  operational_control_strobes #(
    .SETTLE_CYCLES (SETTLE)
  ) u_operational_control_strobes (
    .pclk             (pclk),
    .presetn          (presetn),
    .paddr            (paddr),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .syspll_enable    (syspll_enable),
    .tune_in_range    (tune_in_range),
    .amp_in_range     (amp_in_range),
    .dist_stall       (dist_stall),
    .dist_sync        (dist_sync),
    .core_clock_stall (core_clock_stall),
    .vco_band         (vco_band),
    .vco_amp          (vco_amp),
    .cal_done         (cal_done),
    .func_strobe      (func_strobe),
    .irq_clear        (irq_clear)
  );

  // ==========================================================================
  // Clock, oscillator stand-in and watchdog on the run
  always #5 pclk = ~pclk;

  // Band 5 and amplitude 3 are the only acceptable settings
  always @(posedge pclk)
  begin
    tune_in_range <= (vco_band === 4'h5);
    amp_in_range  <= (vco_amp === 3'h3);
  end

  // Counted on the pulse itself, so a check just after the stall falls sees it
  always @(posedge cal_done)
    done_cnt++;

  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == TIMEOUT_CYCLES)
    begin
      num_errors++;
      summarize();
    end
  end

  // ==========================================================================
  // Tasks
  function automatic logic [15:0] addr_of(input logic [11:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    apb(1'b1, addr_of(idx), d, rd, err);
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, addr_of(idx), 32'h0000_0000, rd, err);
    `CHK(rd, exp, "register read data")
    `CHK(err, 1'b0, "read refused")
  endtask

  // Outputs just after the write edge, then back to idle one cycle later
  task automatic pulse(input opctl_pkg::func_strobe_t ef, input opctl_pkg::irq_clear_t ei, input logic es);
    #1;
    `CHK(func_strobe, ef, "function strobe")
    `CHK(irq_clear, ei, "interrupt clear strobe")
    `CHK(dist_sync, es, "sync pulse")
    @(posedge pclk);
    #1;
    `CHK(func_strobe, 7'h00, "function strobe not single cycle")
    `CHK(irq_clear, 32'h0000_0000, "interrupt clear not single cycle")
    `CHK(dist_sync, 1'b0, "sync pulse not single cycle")
  endtask

  task automatic wait_stall(input logic lvl, output logic seen);
    seen = 1'b0;
    repeat (200)
    begin
      @(posedge pclk);
      #1;
      if (core_clock_stall === lvl)
      begin
        seen = 1'b1;
        break;
      end
    end
  endtask

  task automatic summarize();
    $display("Comparisons: %0d, mismatches: %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    pclk          = 1'b0;
    presetn       = 1'b0;
    psel          = 1'b0;
    penable       = 1'b0;
    pwrite        = 1'b0;
    paddr         = 16'h0000;
    pwdata        = 32'h0000_0000;
    syspll_enable = 1'b1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    `CHK({dist_stall, core_clock_stall, vco_band, vco_amp}, 9'h000, "reset levels")
    rd_chk(opctl_pkg::CALSYNC_IDX, 32'h0000_0000);
    wr(opctl_pkg::CALSYNC_IDX, 32'hFFFF_FFFC);
    rd_chk(opctl_pkg::CALSYNC_IDX, 32'h0000_0000);
    wr(opctl_pkg::CALSYNC_IDX, 32'h0000_0002);
    pulse('0, '0, 1'b0);
    `CHK(dist_stall, 1'b1, "distribution not stalled")
    rd_chk(opctl_pkg::CALSYNC_IDX, 32'h0000_0002);
    wr(opctl_pkg::CALSYNC_IDX, 32'h0000_0000);
    pulse('0, '0, 1'b1);
    `CHK(dist_stall, 1'b0, "distribution still stalled")
    wr(opctl_pkg::CALSYNC_IDX, 32'h0000_0000);
    pulse('0, '0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      wr(opctl_pkg::FUNC_IDX, 32'h1 << i);
      pulse(7'((i < 7) ? (1 << i) : 0), (i == opctl_pkg::FUNC_CLR_ALL) ? {opctl_pkg::LIMIT_MASK, opctl_pkg::PLL_MASK,
            opctl_pkg::MISC_MASK, opctl_pkg::CORE_REFERENCE_CLOCK_MASK} : 32'h0000_0000, 1'b0);
    end
    rd_chk(opctl_pkg::FUNC_IDX, 32'h0000_0000);
    for (int k = 0; k < 4; k++)
    begin
      wr(opctl_pkg::CORE_REFERENCE_CLOCK_CLR_IDX + 12'(k), 32'hFFFF_FFFF);
      pulse('0, 32'(irq_masks[k]) << (8 * k), 1'b0);
      wr(opctl_pkg::CORE_REFERENCE_CLOCK_CLR_IDX + 12'(k), 32'h0000_0001);
      pulse('0, 32'h1 << (8 * k), 1'b0);
      rd_chk(opctl_pkg::CORE_REFERENCE_CLOCK_CLR_IDX + 12'(k), 32'h0000_0000);
    end
    apb(1'b0, 16'h2880, 32'h0000_0000, rd, err);
    `CHK({err, rd}, 33'h1_0000_0000, "unmapped read")
    // Calibration, a refused write while stalled, then the recalibration order
    wr(opctl_pkg::CALSYNC_IDX, 32'h0000_0001);
    wr(opctl_pkg::UPDATE_IDX, 32'h0000_0001);
    wait_stall(1'b1, hit);
    `CHK(hit, 1'b1, "calibration did not start")
    apb(1'b1, addr_of(opctl_pkg::FUNC_IDX), 32'h0000_0001, rd, err);
    `CHK(err, 1'b1, "write accepted while stalled")
    pulse('0, '0, 1'b0);
    wait_stall(1'b0, hit);
    `CHK(hit, 1'b1, "calibration did not end")
    `CHK({vco_band, vco_amp}, 7'h2B, "chosen band and amplitude")
    `CHK(done_cnt, 1, "calibration done pulses")
    rd_chk(opctl_pkg::STATUS_IDX, 32'h0000_0354);
    wr(opctl_pkg::UPDATE_IDX, 32'h0000_0001);
    wait_stall(1'b1, hit);
    `CHK(hit, 1'b0, "restart without a zero commit")
    wr(opctl_pkg::CALSYNC_IDX, 32'h0000_0000);
    wr(opctl_pkg::UPDATE_IDX, 32'h0000_0001);
    wr(opctl_pkg::CALSYNC_IDX, 32'h0000_0001);
    wr(opctl_pkg::UPDATE_IDX, 32'h0000_0001);
    wait_stall(1'b1, hit);
    `CHK(hit, 1'b1, "recalibration did not start")
    wait_stall(1'b0, hit);
    `CHK(done_cnt, 2, "second calibration done")
    wr(opctl_pkg::CALSYNC_IDX, 32'h0000_0000);
    wr(opctl_pkg::UPDATE_IDX, 32'h0000_0001);
    syspll_enable <= 1'b0;
    wr(opctl_pkg::CALSYNC_IDX, 32'h0000_0001);
    wr(opctl_pkg::UPDATE_IDX, 32'h0000_0001);
    wait_stall(1'b1, hit);
    `CHK(hit, 1'b0, "calibration with the PLL disabled")
    summarize();
  end
endmodule
